// *** verilog/lpt_port_pkg.sv ***
// constants, types and address map for the printer parallel port
package lpt_port_pkg;

  // ---------------------------------------------------------------
  // system i/o addresses
  // ---------------------------------------------------------------
  localparam logic [15:0] OPT_SEL_ADDR = 16'h0102;
  localparam logic [15:0] BASE_PAR1 = 16'h03bc;
  localparam logic [15:0] BASE_PAR2 = 16'h0378;
  localparam logic [15:0] BASE_PAR3 = 16'h0278;
  localparam logic [15:0] OFS_DATA = 16'h0000;
  localparam logic [15:0] OFS_STATUS = 16'h0001;
  localparam logic [15:0] OFS_CTRL = 16'h0002;

  // ---------------------------------------------------------------
  // option-select fields
  // ---------------------------------------------------------------
  localparam int OPT_COMPAT_BIT = 7;
  localparam int OPT_BASE_HI = 6;
  localparam int OPT_BASE_LO = 5;
  localparam logic [1:0] BASE_SEL_PAR1 = 2'h0;
  localparam logic [1:0] BASE_SEL_PAR2 = 2'h1;
  localparam logic [1:0] BASE_SEL_PAR3 = 2'h2;
  localparam logic [7:0] OPT_RESET = 8'h80;

  // ---------------------------------------------------------------
  // control register, bit 5 down to bit 0
  // ---------------------------------------------------------------
  typedef struct packed {
    logic dir_read;
    logic irq_en;
    logic choose_printer;
    logic init;
    logic linefeed_automatic;
    logic strobe;
  } ctrl_type;

  localparam int CTRL_W = 6;
  localparam ctrl_type CTRL_RESET = 6'h04;
  localparam logic [1:0] CTRL_RSVD = 2'h0;

  // ---------------------------------------------------------------
  // filtered printer-side status inputs
  // ---------------------------------------------------------------
  typedef struct packed {
    logic busy;
    logic ack_n;
    logic paper_out;
    logic printer_chosen;
    logic error_n;
  } pin_stat_type;

  localparam int STAT_PINS = 5;
  localparam int DATA_W = 8;
  localparam int SYNC_W = DATA_W + STAT_PINS;
  localparam logic [1:0] STAT_RSVD = 2'h0;
  localparam int STAT_IRQ_BIT = 2;
  // idle pin levels: acknowledge and error high, data and the rest low
  localparam logic [SYNC_W-1:0] SYNC_RESET = 13'h0009;

endpackage

// *** verilog/printer_parallel_port.sv ***
// printer parallel port: i/o-mapped data, status and control ports
`timescale 1ns/10ps
module printer_parallel_port
  import lpt_port_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rstn,
  input wire logic i_setup,
  input wire logic [15:0] i_io_addr,
  input wire logic i_io_wr,
  input wire logic i_io_rd,
  input wire logic [7:0] i_io_wdata,
  output logic [7:0] o_io_rdata,
  output logic o_io_rvalid,
  output logic o_irq,
  input wire logic [7:0] i_pd,
  output logic [7:0] o_pd,
  output logic o_pd_oe,
  input wire logic i_busy,
  input wire logic i_ack_n,
  input wire logic i_paper_out,
  input wire logic i_printer_chosen,
  input wire logic i_error_n,
  output logic o_strobe_n,
  output logic o_linefeed_automatic_n,
  output logic o_init_n,
  output logic o_choose_printer_n
);

  // ---------------------------------------------------------------
  // pin input filters
  // ---------------------------------------------------------------
  // pins are asynchronous; a level only counts once two stages agree
  logic [SYNC_W-1:0] raw_in;
  logic [SYNC_W-1:0] s1_r;
  logic [SYNC_W-1:0] s2_r;
  logic [SYNC_W-1:0] s3_r;
  logic [SYNC_W-1:0] filt_r;

  assign raw_in = {i_pd, i_busy, i_ack_n, i_paper_out, i_printer_chosen, i_error_n};

  genvar gi;
  generate
    for (gi = 0; gi < SYNC_W; gi++) begin : g_sync
      // reset to idle levels, else acknowledge shows a false trailing edge
      always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
          s1_r[gi] <= SYNC_RESET[gi];
          s2_r[gi] <= SYNC_RESET[gi];
          s3_r[gi] <= SYNC_RESET[gi];
          filt_r[gi] <= SYNC_RESET[gi];
        end else begin
          s1_r[gi] <= raw_in[gi];
          s2_r[gi] <= s1_r[gi];
          s3_r[gi] <= s2_r[gi];
          if (s2_r[gi] == s3_r[gi]) begin
            filt_r[gi] <= s3_r[gi];
          end
        end
      end
    end
  endgenerate

  pin_stat_type pin_stat;
  logic [DATA_W-1:0] pd_in;

  assign pin_stat = filt_r[STAT_PINS-1:0];
  assign pd_in = filt_r[SYNC_W-1:STAT_PINS];

  // ---------------------------------------------------------------
  // address decode
  // ---------------------------------------------------------------
  logic [7:0] opt_r;
  logic [1:0] base_sel;
  logic [15:0] base_addr;
  logic [15:0] addr_data;
  logic [15:0] addr_stat;
  logic [15:0] addr_ctrl;
  logic ext_mode;
  logic hit_data;
  logic hit_stat;
  logic hit_ctrl;
  logic wr_opt;
  logic wr_data;
  logic wr_ctrl;
  logic rd_stat;
  logic rd_any;

  assign base_sel = opt_r[OPT_BASE_HI:OPT_BASE_LO];
  assign base_addr = (base_sel == BASE_SEL_PAR2) ? BASE_PAR2 :
                     (base_sel == BASE_SEL_PAR3) ? BASE_PAR3 : BASE_PAR1;
  assign ext_mode = ~opt_r[OPT_COMPAT_BIT];
  assign addr_data = 16'(base_addr + OFS_DATA);
  assign addr_stat = 16'(base_addr + OFS_STATUS);
  assign addr_ctrl = 16'(base_addr + OFS_CTRL);
  assign hit_data = (i_io_addr == addr_data);
  assign hit_stat = (i_io_addr == addr_stat);
  assign hit_ctrl = (i_io_addr == addr_ctrl);
  assign wr_opt = i_io_wr && i_setup && (i_io_addr == OPT_SEL_ADDR);
  assign wr_data = i_io_wr && hit_data;
  assign wr_ctrl = i_io_wr && hit_ctrl;
  assign rd_stat = i_io_rd && hit_stat;
  assign rd_any = i_io_rd && (hit_data || hit_stat || hit_ctrl);

  // ---------------------------------------------------------------
  // option-select, data latch and control registers
  // ---------------------------------------------------------------
  logic [DATA_W-1:0] data_r;
  ctrl_type ctrl_r;

  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      opt_r <= OPT_RESET;
    end else if (wr_opt) begin
      opt_r <= i_io_wdata;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      data_r <= '0;
      ctrl_r <= CTRL_RESET;
    end else begin
      if (wr_data) begin
        data_r <= i_io_wdata;
      end
      if (wr_ctrl) begin
        ctrl_r <= i_io_wdata[CTRL_W-1:0];
      end
    end
  end

  // ---------------------------------------------------------------
  // data pins
  // ---------------------------------------------------------------
  // direction bit is ignored in compatible mode, so reset leaves pins driven
  logic drive_pd;

  assign drive_pd = !ext_mode || !ctrl_r.dir_read;
  assign o_pd = data_r;
  assign o_pd_oe = drive_pd;

  // ---------------------------------------------------------------
  // control pins
  // ---------------------------------------------------------------
  assign o_strobe_n = ~ctrl_r.strobe;
  assign o_linefeed_automatic_n = ~ctrl_r.linefeed_automatic;
  assign o_init_n = ctrl_r.init;
  assign o_choose_printer_n = ~ctrl_r.choose_printer;

  // ---------------------------------------------------------------
  // acknowledge interrupt
  // ---------------------------------------------------------------
  // pending is set on every trailing edge so software can poll it;
  // the enable only gates the interrupt line
  logic ack_prev_r;
  logic ack_rise;
  logic pend_r;

  assign ack_rise = pin_stat.ack_n && !ack_prev_r;

  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      ack_prev_r <= 1'b1;
      pend_r <= 1'b0;
    end else begin
      ack_prev_r <= pin_stat.ack_n;
      if (ack_rise) begin
        pend_r <= 1'b1;
      end else if (rd_stat) begin
        pend_r <= 1'b0;
      end
    end
  end

  assign o_irq = pend_r && ctrl_r.irq_en;

  // ---------------------------------------------------------------
  // read data
  // ---------------------------------------------------------------
  logic [7:0] stat_byte;
  logic [7:0] ctrl_byte;
  logic [7:0] data_byte;
  logic [7:0] rdata_nxt;

  assign stat_byte = {~pin_stat.busy, pin_stat.ack_n, pin_stat.paper_out,
                      pin_stat.printer_chosen, pin_stat.error_n,
                      ~pend_r, STAT_RSVD};
  assign ctrl_byte = {CTRL_RSVD, 1'b0, ctrl_r[CTRL_W-2:0]};
  assign data_byte = drive_pd ? data_r : pd_in;
  assign rdata_nxt = hit_stat ? stat_byte : hit_ctrl ? ctrl_byte : data_byte;

  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      o_io_rdata <= '0;
      o_io_rvalid <= 1'b0;
    end else begin
      o_io_rvalid <= rd_any;
      if (rd_any) begin
        o_io_rdata <= rdata_nxt;
      end
    end
  end

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_rstn);

  sequence seq_ack_rise_en;
    ack_rise && ctrl_r.irq_en && !wr_ctrl;
  endsequence

  sequence seq_irq_seen;
    o_irq && !stat_byte[STAT_IRQ_BIT];
  endsequence

  sequence seq_stat_clear;
    rd_stat && !ack_rise;
  endsequence

  busy_status_a: assert property (rd_stat |=> o_io_rvalid &&
    (o_io_rdata[7] == ~$past(pin_stat.busy)))
    else $error("status bit 7 does not follow busy");

  ack_status_a: assert property (rd_stat |=> o_io_rdata[6] == $past(pin_stat.ack_n))
    else $error("status bit 6 does not follow acknowledge");

  pin_status_a: assert property (rd_stat |=>
    o_io_rdata[5:3] == $past({pin_stat.paper_out, pin_stat.printer_chosen, pin_stat.error_n}))
    else $error("status bits 5 to 3 do not follow pins");

  irq_pending_a: assert property (ack_rise |=> !stat_byte[STAT_IRQ_BIT] ##0 pend_r)
    else $error("pending flag not shown after acknowledge edge");

  ctrl_store_a: assert property (wr_ctrl |=> ctrl_r == $past(i_io_wdata[CTRL_W-1:0]))
    else $error("control write not stored");

  ctrl_read_a: assert property (i_io_rd && hit_ctrl |=>
    o_io_rdata == {3'h0, $past(ctrl_r.irq_en), $past(ctrl_r[3:0])})
    else $error("control read back wrong");

  dir_compat_a: assert property (!ext_mode |-> o_pd_oe)
    else $error("data pins released in compatible mode");

  irq_raise_a: assert property (seq_ack_rise_en |=> seq_irq_seen)
    else $error("interrupt not raised on acknowledge edge");

  irq_gate_a: assert property (!ctrl_r.irq_en |-> !o_irq)
    else $error("interrupt raised while disabled");

  ctrl_pins_a: assert property (wr_ctrl |=>
    {o_choose_printer_n, o_init_n, o_linefeed_automatic_n, o_strobe_n} ==
    {~$past(i_io_wdata[3]), $past(i_io_wdata[2]), ~$past(i_io_wdata[1]),
     ~$past(i_io_wdata[0])})
    else $error("control pins do not follow written bits");

  data_drive_a: assert property (wr_data && !ext_mode |=> o_pd_oe &&
    (o_pd == $past(i_io_wdata)))
    else $error("compatible write not driven on pins");

  ext_read_a: assert property (i_io_rd && hit_data && ext_mode && ctrl_r.dir_read |=>
    !o_pd_oe && (o_io_rdata == $past(pd_in)))
    else $error("extended read does not return pin levels");

  opt_mode_a: assert property (wr_opt |=> ext_mode == !$past(i_io_wdata[7]))
    else $error("mode not taken from option write");

  base_map_a: assert property (wr_opt && (i_io_wdata[6:5] == BASE_SEL_PAR2) |=>
    base_addr == BASE_PAR2)
    else $error("base address not selected");

  pend_clear_a: assert property (seq_stat_clear |=> stat_byte[STAT_IRQ_BIT])
    else $error("pending flag not cleared by status read");

  stat_rsvd_a: assert property (rd_stat |=> o_io_rdata[1:0] == STAT_RSVD)
    else $error("reserved status bits not zero");

  data_read_a: assert property (i_io_rd && hit_data && drive_pd |=>
    o_io_rdata == $past(data_r))
    else $error("data read does not return the latch");

  ext_release_a: assert property (ext_mode && ctrl_r.dir_read |-> !o_pd_oe)
    else $error("data pins driven while direction is read");

  opt_guard_a: assert property (i_io_wr && !i_setup |=> $stable(opt_r))
    else $error("option register changed outside setup");

  unmapped_rd_a: assert property (i_io_rd && !hit_data && !hit_stat && !hit_ctrl |=>
    !o_io_rvalid)
    else $error("read answered at an unmapped address");

endmodule

// *** sim/printer_model.sv ***
// behavioural printer on the far side of the parallel port
`timescale 1ns/10ps
module printer_model (
  input wire logic i_clk,
  input wire logic i_rstn,
  input wire logic i_strobe_n,
  input wire logic i_pd_oe,
  input wire logic [7:0] i_pd_drv,
  input wire logic [7:0] i_peer_byte,
  output logic [7:0] o_pd_wire,
  output logic o_busy,
  output logic o_ack_n
);
  int cnt;
  logic strobe_last_r;
  // port drives the lines while enabled, otherwise the printer side does
  assign o_pd_wire = i_pd_oe ? i_pd_drv : i_peer_byte;
  // -------------------------------------------------------------
  // byte taken on strobe: busy, then an acknowledge pulse
  // -------------------------------------------------------------
  always @(posedge i_clk) begin
    if (!i_rstn) begin
      cnt <= 0;
      o_busy <= 1'b0;
      o_ack_n <= 1'b1;
      strobe_last_r <= 1'b1;
    end else begin
      strobe_last_r <= i_strobe_n;
      if (cnt == 0) begin
        if (strobe_last_r && !i_strobe_n) begin
          cnt <= 1;
          o_busy <= 1'b1;
        end
      end else begin
        cnt <= cnt + 1;
        o_ack_n <= !(cnt >= 3 && cnt < 7);
        if (cnt == 8) begin
          cnt <= 0;
          o_busy <= 1'b0;
        end
      end
    end
  end
endmodule

// *** sim/tb_top.sv ***
// self-checking bench for the printer parallel port
`timescale 1ns/10ps
module tb_top;
  import lpt_port_pkg::*;
  logic i_clk, i_rstn, i_setup, i_io_wr, i_io_rd, rvalid, irq, pd_oe;
  logic busy, ack_n, pe, chosen, err_n, strobe_n, lf_n, init_n, choose_n, seen;
  logic [15:0] addr, base_m;
  logic [7:0] wdata, rdata, pd_in, pd_out, peer, rq, d;
  int mismatches, checks_done;
  printer_parallel_port u_printer_parallel_port (.i_clk(i_clk), .i_rstn(i_rstn),
    .i_setup(i_setup), .i_io_addr(addr), .i_io_wr(i_io_wr), .i_io_rd(i_io_rd),
    .i_io_wdata(wdata), .o_io_rdata(rdata), .o_io_rvalid(rvalid), .o_irq(irq),
    .i_pd(pd_in), .o_pd(pd_out), .o_pd_oe(pd_oe), .i_busy(busy), .i_ack_n(ack_n),
    .i_paper_out(pe), .i_printer_chosen(chosen), .i_error_n(err_n),
    .o_strobe_n(strobe_n), .o_linefeed_automatic_n(lf_n), .o_init_n(init_n),
    .o_choose_printer_n(choose_n));
  printer_model u_printer_model (.i_clk(i_clk), .i_rstn(i_rstn), .i_strobe_n(strobe_n),
    .i_pd_oe(pd_oe), .i_pd_drv(pd_out), .i_peer_byte(peer), .o_pd_wire(pd_in),
    .o_busy(busy), .o_ack_n(ack_n));
  initial begin
    i_clk = 1'b0;
    forever #50 i_clk = ~i_clk;
  end
  // -------------------------------------------------------------
  // bus tasks and comparison
  // -------------------------------------------------------------
  task chk(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task end_sim;
    $display("mismatches=%0d checks_done=%0d", mismatches, checks_done);
    if (mismatches == 0 && checks_done > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task wr(input logic [15:0] a, input logic [7:0] v);
    @(posedge i_clk);
    i_io_wr <= 1'b1;
    addr <= a;
    wdata <= v;
    @(posedge i_clk);
    i_io_wr <= 1'b0;
    #1;
  endtask
  // one-cycle strobe; answer is looked for in the cycles after
  task rd(input logic [15:0] a, input logic want);
    @(posedge i_clk);
    i_io_rd <= 1'b1;
    addr <= a;
    @(posedge i_clk);
    i_io_rd <= 1'b0;
    seen = 1'b0;
    for (int k = 0; k < 3 && !seen; k++) begin
      #1;
      if (rvalid === 1'b1) begin
        seen = 1'b1;
        rq = rdata;
      end else @(posedge i_clk);
    end
    if (want && !seen) begin
      mismatches++;
      end_sim();
    end
  endtask
  function automatic logic [7:0] stat_m(input logic pend);
    return {~busy, ack_n, pe, chosen, err_n, ~pend, STAT_RSVD};
  endfunction
  // -------------------------------------------------------------
  // main sequence
  // -------------------------------------------------------------
  initial begin
    mismatches = 0;
    checks_done = 0;
    {i_rstn, i_setup, i_io_wr, i_io_rd, addr, wdata, peer} = '0;
    {pe, chosen, err_n} = 3'b011;
    base_m = BASE_PAR1;
    void'($urandom(20));
    repeat (12) @(posedge i_clk);
    i_rstn <= 1'b1;
    chk({strobe_n, lf_n, init_n, choose_n, pd_oe}, 8'h1f);
    rd(base_m + OFS_CTRL, 1'b1);
    chk(rq, 8'h04);
    for (int i = 0; i < 8; i++) begin
      d = 8'($urandom) & 8'hfe;
      wr(base_m + OFS_CTRL, d);
      chk({strobe_n, lf_n, init_n, choose_n, pd_oe}, {3'h0, ~d[0], ~d[1], d[2], ~d[3], 1'b1});
      rd(base_m + OFS_CTRL, 1'b1);
      chk(rq, d & 8'h1f);
      d = 8'($urandom);
      wr(base_m + OFS_DATA, d);
      chk(pd_out, d);
      rd(base_m + OFS_DATA, 1'b1);
      chk(rq, d);
      {pe, chosen, err_n} <= 3'($urandom);
      repeat (8) @(posedge i_clk);
      rd(base_m + OFS_STATUS, 1'b1);
      chk(rq, stat_m(1'b0));
    end
    // acknowledge interrupt with enable set, then with enable clear
    for (int e = 1; e >= 0; e--) begin
      wr(base_m + OFS_CTRL, {3'h0, 1'(e), 4'h5});
      chk(strobe_n, 8'h0);
      wr(base_m + OFS_CTRL, {3'h0, 1'(e), 4'h4});
      // printer is busy for several cycles after the strobe
      repeat (3) @(posedge i_clk);
      rd(base_m + OFS_STATUS, 1'b1);
      chk(rq[7], 8'h0);
      seen = 1'b0;
      repeat (30) begin
        @(posedge i_clk);
        #1;
        seen = seen | irq;
      end
      chk(seen, 8'(e));
      rd(base_m + OFS_STATUS, 1'b1);
      chk(rq, stat_m(1'b1));
      chk(irq, 8'h0);
      rd(base_m + OFS_STATUS, 1'b1);
      chk(rq, stat_m(1'b0));
    end
    // extended mode at the second base, direction both ways
    i_setup <= 1'b1;
    wr(OPT_SEL_ADDR, 8'h20);
    base_m = BASE_PAR2;
    wr(base_m + OFS_CTRL, 8'h24);
    chk(pd_oe, 8'h0);
    peer <= 8'($urandom);
    repeat (8) @(posedge i_clk);
    rd(base_m + OFS_DATA, 1'b1);
    chk(rq, peer);
    d = 8'($urandom);
    wr(base_m + OFS_DATA, d);
    chk(pd_in, peer);
    wr(base_m + OFS_CTRL, 8'h04);
    chk(pd_in, d);
    rd(base_m + OFS_DATA, 1'b1);
    chk(rq, d);
    i_setup <= 1'b0;
    wr(OPT_SEL_ADDR, 8'hc0);
    rd(base_m + OFS_CTRL, 1'b1);
    chk(rq, 8'h04);
    rd(BASE_PAR1 + OFS_CTRL, 1'b0);
    chk(seen, 8'h0);
    i_setup <= 1'b1;
    for (int s = 0; s < 3; s++) begin
      wr(OPT_SEL_ADDR, 8'h80 | 8'(s << 5));
      base_m = (s == 0) ? BASE_PAR1 : (s == 1) ? BASE_PAR2 : BASE_PAR3;
      wr(base_m + OFS_CTRL, 8'h24);
      chk(pd_oe, 8'h1);
      rd(base_m + OFS_CTRL, 1'b1);
      chk(rq, 8'h04);
    end
    end_sim();
  end
endmodule
